//--- src/pcc_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 25 MHz aclk, one 64-byte register window per channel
// Notes:   Byte offsets are relative to the channel window base
`ifndef PCC_DEFS_SVH
`define PCC_DEFS_SVH
`define PCC_CH_SHIFT   6
`define PCC_O_CFG      6'h00
`define PCC_O_VAL      6'h04
`define PCC_O_LTIME    6'h08
`define PCC_O_THR      6'h0C
`define PCC_O_HYST     6'h10
`define PCC_O_BRIGHT   6'h14
`define PCC_O_LOCK     6'h18
`define PCC_O_EXTMV    6'h1C
`define PCC_O_MANUAL   6'h20
`define PCC_O_RELDIM   6'h24
`define PCC_O_ABSDIM   6'h28
`define PCC_O_FORCE    6'h2C
`define PCC_O_FVAL     6'h30
`define PCC_O_TIMES    6'h34
`define PCC_O_STATUS   6'h38
`define PCC_CFG_APP    0
`define PCC_CFG_BIND   1
`define PCC_CFG_PDEP   2
`define PCC_CFG_EXTEN  3
`define PCC_CFG_LPOL   4
`define PCC_CFG_LSEND  5
`define PCC_CFG_F2BIT  6
`define PCC_RST_CFG    8'h0C
`define PCC_RST_ON     8'hFF
`define PCC_RST_OFF    8'h00
`define PCC_RST_LOCKV  8'h00
`define PCC_RST_FVAL   8'h80
`define PCC_RST_LTIME  16'h003C
`define PCC_RST_THR    16'h012C
`define PCC_RST_HYST   16'h0032
`define PCC_RST_MANT   16'h012C
`define PCC_RST_DIMT   16'h0005
`define PCC_LT_MIN     16'h000A
`define PCC_LT_MAX     16'hFFFF
`define PCC_THR_MIN    16'h0001
`define PCC_THR_MAX    16'h04B0
`define PCC_CLK_NS     40
`define PCC_SEC_NS     1000000000
`define PCC_SEC_CYC    (`PCC_SEC_NS / `PCC_CLK_NS)
`define PCC_SUB_DIV    256
`endif

//--- src/pcc_pkg.sv
// Purpose: Types shared by the presence channel controller
// Assumes: Four channels, packed state
// Notes:   Whole module state is one packed struct
`default_nettype none
package pcc_pkg;
  typedef enum logic [1:0] {PCC_AUTO, PCC_MANUAL, PCC_FORCED} pcc_mode_t;
  typedef struct packed {
    logic [7:0]  cfg;
    logic [7:0]  onv;
    logic [7:0]  offv;
    logic [7:0]  lockv;
    logic [15:0] lt;
    logic [15:0] thr;
    logic [15:0] hyst;
    logic [15:0] bright;
    logic [7:0]  fval;
    logic [15:0] mant;
    logic [15:0] dimt;
    pcc_mode_t   mode;
    logic        locked;
    logic        dark;
    logic        occ;
    logic [15:0] lt_cnt;
    logic [15:0] man_cnt;
    logic [7:0]  level;
    logic [7:0]  target;
    logic [15:0] ramp;
    logic [7:0]  lastv;
    logic        ms1;
    logic        ms2;
    logic        send;
    logic [7:0]  val;
    logic        ssend;
    logic        sauto;
  } pcc_ch_t;
  typedef struct packed {
    pcc_ch_t [3:0] ch;
    logic [31:0]   sub;
    logic [7:0]    subn;
    logic          stick;
    logic          tick;
    logic          have_aw;
    logic          have_w;
    logic [8:0]    awaddr;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          awrdy;
    logic          wrdy;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arrdy;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
  } pcc_st_t;
endpackage
`default_nettype wire

//--- src/pcc_top.sv
// Purpose: Four presence channels behind an AXI4-Lite register slave
// Assumes: Synchronous active-low reset, motion pins asynchronous
// Notes:   Telegrams arrive as register writes; send outputs are one-cycle pulses, values and auto flags hold
`default_nettype none
`include "pcc_defs.svh"
//////////////////////////////////////////////////////////////////////////////
module pcc_top #(
  parameter int unsigned SEC_CYCLES = `PCC_SEC_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [3:0]  motion_in,
  output logic [3:0]       out_send,
  output logic [31:0]      out_value,
  output logic [3:0]       stat_send,
  output logic [3:0]       stat_auto
);
  localparam int unsigned SUB_CYCLES = SEC_CYCLES / `PCC_SUB_DIV;

  pcc_pkg::pcc_st_t q;
  pcc_pkg::pcc_st_t d;
  logic             wr_go;

  assign wr_go = q.have_aw & q.have_w & ~q.bvalid;

  //////////////////////////////////////////////////////////////////////////
  function automatic logic pcc_mapped(input logic [8:0] a);
    pcc_mapped = ~a[8] & (a[5:2] <= 4'hE) & (a[1:0] == 2'h0);
  endfunction

  function automatic logic [15:0] pcc_clamp(input logic [15:0] v,
                                            input logic [15:0] lo,
                                            input logic [15:0] hi);
    pcc_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [31:0] pcc_rd(input pcc_pkg::pcc_ch_t c,
                                         input logic [5:0] off);
    case (off)
      `PCC_O_CFG:    pcc_rd = {24'h000000, c.cfg};
      `PCC_O_VAL:    pcc_rd = {8'h00, c.lockv, c.offv, c.onv};
      `PCC_O_LTIME:  pcc_rd = {16'h0000, c.lt};
      `PCC_O_THR:    pcc_rd = {16'h0000, c.thr};
      `PCC_O_HYST:   pcc_rd = {16'h0000, c.hyst};
      `PCC_O_BRIGHT: pcc_rd = {16'h0000, c.bright};
      `PCC_O_FVAL:   pcc_rd = {24'h000000, c.fval};
      `PCC_O_TIMES:  pcc_rd = {c.dimt, c.mant};
      `PCC_O_STATUS: pcc_rd = {c.lt_cnt, c.level, 3'h0, c.dark, c.occ,
                               c.mode == pcc_pkg::PCC_FORCED,
                               c.mode == pcc_pkg::PCC_MANUAL, c.locked};
      default:       pcc_rd = 32'h00000000;
    endcase
  endfunction

  function automatic logic [31:0] pcc_merge(input logic [31:0] o,
                                            input logic [31:0] n,
                                            input logic [3:0]  s);
    for (int b = 0; b < 4; b++) begin
      pcc_merge[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    pcc_pkg::pcc_ch_t c;
    logic [31:0]      nv;
    logic             we;
    logic             mot;
    logic             want;
    logic [7:0]       av;
    logic [7:0]       step;
    logic [16:0]      lo;
    logic [16:0]      hi;
    logic [8:0]       sum;
    d    = q;
    c    = q.ch[0];
    nv   = 32'h00000000;
    we   = 1'b0;
    mot  = 1'b0;
    want = 1'b0;
    av   = 8'h00;
    step = 8'h00;
    lo   = 17'h00000;
    hi   = 17'h00000;
    sum  = 9'h000;
    // Sub-second tick for ramps, 256 of them make the seconds tick
    d.stick = 1'b0;
    d.tick  = 1'b0;
    d.sub   = q.sub + 32'h00000001;
    if (q.sub >= 32'(SUB_CYCLES - 1)) begin
      d.sub   = 32'h00000000;
      d.stick = 1'b1;
      d.subn  = q.subn + 8'h01;
      d.tick  = (q.subn == 8'hFF);
    end
    // Write address and data are taken independently
    if (awvalid & q.awrdy) begin
      d.have_aw = 1'b1;
      d.awaddr  = {|awaddr[31:8], awaddr[7:0]};
    end
    if (wvalid & q.wrdy) begin
      d.have_w = 1'b1;
      d.wdata  = wdata;
      d.wstrb  = wstrb;
    end
    if (q.bvalid & bready) begin
      d.bvalid = 1'b0;
    end
    if (wr_go) begin
      d.have_aw = 1'b0;
      d.have_w  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = pcc_mapped(q.awaddr) ? 2'h0 : 2'h2;
    end
    if (q.rvalid & rready) begin
      d.rvalid = 1'b0;
    end
    if (arvalid & q.arrdy) begin
      d.rvalid = 1'b1;
      d.rresp  = pcc_mapped({|araddr[31:8], araddr[7:0]}) ? 2'h0 : 2'h2;
      d.rdata  = pcc_rd(q.ch[araddr[7:6]], araddr[5:0]);
      if (|araddr[31:8]) begin
        d.rdata = 32'h00000000;
      end
    end
    d.awrdy = ~d.have_aw;
    d.wrdy  = ~d.have_w;
    d.arrdy = ~d.rvalid;
    for (int i = 0; i < 4; i++) begin
      c       = q.ch[i];
      c.send  = 1'b0;
      c.ssend = 1'b0;
      c.ms1   = motion_in[i];
      c.ms2   = q.ch[i].ms1;
      we = wr_go & pcc_mapped(q.awaddr) & (q.awaddr[7:6] == 2'(i));
      nv = pcc_merge(pcc_rd(q.ch[i], q.awaddr[5:0]), q.wdata, q.wstrb);
      mot = q.ch[i].ms2 | (we & (q.awaddr[5:0] == `PCC_O_EXTMV) & q.wdata[0]
                           & q.ch[i].cfg[`PCC_CFG_EXTEN]);
      mot = mot & ~q.ch[i].locked;
      if (q.tick) begin
        if (c.lt_cnt != 16'h0000) c.lt_cnt = c.lt_cnt - 16'h0001;
        if (c.man_cnt != 16'h0000) c.man_cnt = c.man_cnt - 16'h0001;
      end
      if (mot) begin
        c.lt_cnt = c.lt;
        c.occ    = 1'b1;
      end else if (c.lt_cnt == 16'h0000) begin
        c.occ = 1'b0;
      end
      lo = (c.thr > c.hyst) ? {1'b0, c.thr - c.hyst} : 17'h00000;
      hi = {1'b0, c.thr} + {1'b0, c.hyst};
      if ({1'b0, c.bright} < lo) begin
        c.dark = 1'b1;
      end else if ({1'b0, c.bright} > hi) begin
        c.dark = 1'b0;
      end
      if (c.cfg[`PCC_CFG_APP]) begin
        want = c.cfg[`PCC_CFG_PDEP] ? (c.occ & c.dark) : c.dark;
      end else begin
        want = c.occ & (c.dark | c.cfg[`PCC_CFG_BIND]);
      end
      av = want ? c.onv : c.offv;
      if (c.mode == pcc_pkg::PCC_MANUAL && q.tick && c.man_cnt == 16'h0000) begin
        c.mode  = pcc_pkg::PCC_AUTO;
        c.ssend = 1'b1;
        c.sauto = 1'b1;
        c.send  = 1'b1;
        c.val   = c.occ ? av : c.offv;
        c.lastv = c.val;
      end else if (c.mode == pcc_pkg::PCC_AUTO && !c.locked && av != c.lastv) begin
        c.send  = 1'b1;
        c.val   = av;
        c.lastv = av;
      end
      if (c.mode == pcc_pkg::PCC_MANUAL && c.level != c.target) begin
        if (c.dimt == 16'h0000) begin
          c.level = c.target;
          c.send  = 1'b1;
          c.val   = c.target;
        end else if (q.stick) begin
          c.ramp = c.ramp + 16'h0001;
          if (c.ramp >= c.dimt) begin
            c.ramp  = 16'h0000;
            c.level = (c.level < c.target) ? c.level + 8'h01 : c.level - 8'h01;
            c.send  = 1'b1;
            c.val   = c.level;
          end
        end
      end
      if (we) begin
        case (q.awaddr[5:0])
          `PCC_O_CFG:    c.cfg = nv[7:0];
          `PCC_O_VAL:    {c.lockv, c.offv, c.onv} = nv[23:0];
          `PCC_O_LTIME:  c.lt = pcc_clamp(nv[15:0], `PCC_LT_MIN, `PCC_LT_MAX);
          `PCC_O_THR:    c.thr = pcc_clamp(nv[15:0], `PCC_THR_MIN, `PCC_THR_MAX);
          `PCC_O_HYST:   c.hyst = nv[15:0];
          `PCC_O_BRIGHT: c.bright = nv[15:0];
          `PCC_O_TIMES:  {c.dimt, c.mant} = nv;
          `PCC_O_FVAL:   c.fval = nv[7:0];
          `PCC_O_LOCK: begin
            if (q.wdata[0] == c.cfg[`PCC_CFG_LPOL]) begin
              if (!c.locked && c.cfg[`PCC_CFG_LSEND] &&
                  c.mode != pcc_pkg::PCC_FORCED) begin
                c.send  = 1'b1;
                c.val   = c.lockv;
                c.lastv = c.lockv;
              end
              c.locked = 1'b1;
            end else begin
              c.locked = 1'b0;
            end
          end
          `PCC_O_MANUAL, `PCC_O_RELDIM, `PCC_O_ABSDIM: begin
            if (c.mode != pcc_pkg::PCC_FORCED) begin
              if (c.mode != pcc_pkg::PCC_MANUAL) begin
                c.ssend = 1'b1;
                c.sauto = 1'b0;
                c.level = c.lastv;
                c.target = c.lastv;
                c.ramp  = 16'h0000;
              end
              c.mode    = pcc_pkg::PCC_MANUAL;
              c.man_cnt = c.mant;
              step = 8'hFF >> (q.wdata[2:0] - 3'h1);
              sum  = q.wdata[3] ? {1'b0, c.level} + {1'b0, step}
                                : {1'b0, c.level} - {1'b0, step};
              if (q.awaddr[5:0] == `PCC_O_MANUAL) begin
                c.target = q.wdata[0] ? c.onv : c.offv;
              end else if (q.awaddr[5:0] == `PCC_O_ABSDIM) begin
                c.target = q.wdata[7:0];
              end else if (q.wdata[2:0] == 3'h0) begin
                c.target = c.level;
              end else begin
                c.target = sum[8] ? (q.wdata[3] ? 8'hFF : 8'h00) : sum[7:0];
              end
            end
          end
          `PCC_O_FORCE: begin
            if (c.cfg[`PCC_CFG_F2BIT] ? (q.wdata[1] & q.wdata[0]) : q.wdata[0]) begin
              c.mode  = pcc_pkg::PCC_FORCED;
              c.send  = 1'b1;
              c.val   = c.fval;
              c.lastv = c.fval;
            end else if (c.mode == pcc_pkg::PCC_FORCED &&
                         (c.cfg[`PCC_CFG_F2BIT] ? !q.wdata[1] : !q.wdata[0])) begin
              c.mode  = pcc_pkg::PCC_AUTO;
              c.lastv = ~av;
            end
          end
          default: c.cfg = c.cfg;
        endcase
      end
      d.ch[i] = c;
    end
    if (!aresetn) begin
      d = '0;
      for (int i = 0; i < 4; i++) begin
        d.ch[i].cfg   = `PCC_RST_CFG;
        d.ch[i].onv   = `PCC_RST_ON;
        d.ch[i].offv  = `PCC_RST_OFF;
        d.ch[i].lockv = `PCC_RST_LOCKV;
        d.ch[i].fval  = `PCC_RST_FVAL;
        d.ch[i].lt    = `PCC_RST_LTIME;
        d.ch[i].thr   = `PCC_RST_THR;
        d.ch[i].hyst  = `PCC_RST_HYST;
        d.ch[i].mant  = `PCC_RST_MANT;
        d.ch[i].dimt  = `PCC_RST_DIMT;
        d.ch[i].sauto = 1'b1;
      end
      d.awrdy = 1'b1;
      d.wrdy  = 1'b1;
      d.arrdy = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    q <= d;
  end

  assign awready = q.awrdy;
  assign wready  = q.wrdy;
  assign bvalid  = q.bvalid;
  assign bresp   = q.bresp;
  assign arready = q.arrdy;
  assign rvalid  = q.rvalid;
  assign rresp   = q.rresp;
  assign rdata   = q.rdata;

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  for (genvar g = 0; g < 4; g++) begin : g_ch
    logic we_g;
    assign we_g              = wr_go & ~q.awaddr[8] & (q.awaddr[7:6] == 2'(g));
    assign out_send[g]       = q.ch[g].send;
    assign out_value[g*8 +: 8] = q.ch[g].val;
    assign stat_send[g]      = q.ch[g].ssend;
    assign stat_auto[g]      = q.ch[g].sauto;

    a_lock_engage: assert property (
      we_g && q.awaddr[5:0] == `PCC_O_LOCK &&
      q.wdata[0] == q.ch[g].cfg[`PCC_CFG_LPOL] |=> q.ch[g].locked)
      else $error("lock telegram did not lock channel");
    a_retrig_load: assert property (
      q.ch[g].ms2 && !q.ch[g].locked |=> q.ch[g].lt_cnt == $past(q.ch[g].lt))
      else $error("motion did not restart light-on timer");
    a_lt_clamp: assert property (
      we_g && q.awaddr[5:0] == `PCC_O_LTIME && q.wstrb == 4'hF &&
      q.wdata[15:0] < `PCC_LT_MIN |=> q.ch[g].lt == `PCC_LT_MIN)
      else $error("light-on duration not clamped");
    a_thr_clamp: assert property (
      we_g && q.awaddr[5:0] == `PCC_O_THR && q.wstrb == 4'hF &&
      q.wdata[15:0] > `PCC_THR_MAX |=> q.ch[g].thr == `PCC_THR_MAX)
      else $error("threshold not clamped");
    a_manual_enter: assert property (
      we_g && q.awaddr[5:0] == `PCC_O_ABSDIM && q.ch[g].mode != pcc_pkg::PCC_FORCED
      |=> q.ch[g].mode == pcc_pkg::PCC_MANUAL && q.ch[g].man_cnt != 16'h0000
          || q.ch[g].mant == 16'h0000)
      else $error("manual telegram did not enter manual mode");
    a_status_tel: assert property (
      $changed(q.ch[g].mode == pcc_pkg::PCC_MANUAL) && q.ch[g].mode != pcc_pkg::PCC_FORCED
      |-> q.ch[g].ssend && q.ch[g].sauto == (q.ch[g].mode != pcc_pkg::PCC_MANUAL))
      else $error("mode change without status telegram");
    a_force_value: assert property (
      $rose(q.ch[g].mode == pcc_pkg::PCC_FORCED)
      |-> q.ch[g].send && q.ch[g].val == q.ch[g].fval)
      else $error("forced entry did not send forced value");
    a_force_hold: assert property (
      q.ch[g].mode == pcc_pkg::PCC_FORCED && !(we_g && q.awaddr[5:0] == `PCC_O_FORCE)
      |=> q.ch[g].mode == pcc_pkg::PCC_FORCED)
      else $error("forced state left without release telegram");
    a_dim_instant: assert property (
      q.ch[g].mode == pcc_pkg::PCC_MANUAL && q.ch[g].dimt == 16'h0000 &&
      q.ch[g].level != q.ch[g].target |=> q.ch[g].level == $past(q.ch[g].target)
      && q.ch[g].send)
      else $error("zero dim time did not apply level at once");
  end
endmodule
`default_nettype wire

//--- testbench/pcc_act_model.sv
// Purpose: Lighting actuator side, records output and status telegrams
// Assumes: Telegram pulses last exactly one aclk cycle
// Notes:   Per-channel counts wrap at 256, enough for this bench
`default_nettype none
module pcc_act_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  out_send,
  input  wire logic [31:0] out_value,
  input  wire logic [3:0]  stat_send,
  input  wire logic [3:0]  stat_auto,
  output logic [31:0]      rx_val,
  output logic [31:0]      rx_cnt,
  output logic [3:0]       rx_auto,
  output logic [31:0]      st_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  // A telegram exists only in its pulse cycle, so capture it there
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_val  <= 32'h0;
      rx_cnt  <= 32'h0;
      rx_auto <= 4'hF;
      st_cnt  <= 32'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (out_send[i]) begin
          rx_val[i*8+:8] <= out_value[i*8+:8];
          rx_cnt[i*8+:8] <= rx_cnt[i*8+:8] + 8'h01;
        end
        if (stat_send[i]) begin
          rx_auto[i]     <= stat_auto[i];
          st_cnt[i*8+:8] <= st_cnt[i*8+:8] + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// Purpose: Self-checking bench for the four presence channels
// Assumes: Seconds shortened to 2560 aclk cycles
// Notes:   bready and rready stay high, the master always accepts
`default_nettype none
`include "pcc_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEC = 2560;
  typedef struct packed {
    logic        wr;
    logic [2:0]  ch;
    logic [5:0]  off;
    logic [31:0] wd;
    logic [31:0] ex;
    logic [1:0]  rs;
  } pcc_row_t;
  logic        aclk = 1'b0;
  logic        aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] awaddr, wdata, araddr, rdata, out_value, rx_val, rx_cnt, st_cnt, d;
  logic [3:0]  motion_in, out_send, stat_send, stat_auto, rx_auto;
  logic [1:0]  bresp, rresp, r;
  int          miscompares, checked, cyc, n, s, k, c;
  pcc_row_t    rows [14];
  logic [31:0] br [3];
  logic [7:0]  bx [3];

  pcc_top #(.SEC_CYCLES(SEC)) dut (
    .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
    .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .motion_in, .out_send, .out_value, .stat_send, .stat_auto
  );
  pcc_act_model act (
    .aclk, .aresetn, .out_send, .out_value, .stat_send, .stat_auto,
    .rx_val, .rx_cnt, .rx_auto, .st_cnt
  );

  always #20 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      miscompares++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (miscompares == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] adr(input int ch, input logic [5:0] off);
    return (32'(ch) << `PCC_CH_SHIFT) | {26'h0, off};
  endfunction
  // Valids drop only once taken, so no signal is driven twice per step
  task automatic axw(input logic [31:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
  endtask
  task automatic axr(input logic [31:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready && arvalid) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask
  task automatic wt(input int ch, input logic [7:0] cnt);
    while (rx_cnt[ch*8+:8] !== cnt) @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, awvalid, wvalid, arvalid} = 4'h0;
    {bready, rready} = 2'h3;
    {awaddr, wdata, araddr} = 96'h0;
    motion_in = 4'h0;
    {miscompares, checked} = 64'h0;
    rows = '{'{1'b0, 3'h0, `PCC_O_CFG, 32'h0, 32'h0C, 2'h0},
             '{1'b0, 3'h3, `PCC_O_VAL, 32'h0, 32'hFF, 2'h0},
             '{1'b0, 3'h0, `PCC_O_LTIME, 32'h0, 32'h3C, 2'h0},
             '{1'b0, 3'h1, `PCC_O_THR, 32'h0, 32'h12C, 2'h0},
             '{1'b0, 3'h2, `PCC_O_HYST, 32'h0, 32'h32, 2'h0},
             '{1'b0, 3'h0, `PCC_O_FVAL, 32'h0, 32'h80, 2'h0},
             '{1'b0, 3'h0, `PCC_O_TIMES, 32'h0, 32'h0005012C, 2'h0},
             '{1'b1, 3'h1, `PCC_O_THR, 32'h0, 32'h1, 2'h0},
             '{1'b1, 3'h1, `PCC_O_THR, 32'h1388, 32'h4B0, 2'h0},
             '{1'b1, 3'h1, `PCC_O_THR, 32'h1F4, 32'h1F4, 2'h0},
             '{1'b1, 3'h2, `PCC_O_LTIME, 32'h3, 32'hA, 2'h0},
             '{1'b1, 3'h3, `PCC_O_LTIME, 32'hFFFF, 32'hFFFF, 2'h0},
             '{1'b1, 3'h0, 6'h3C, 32'h5, 32'h0, 2'h2},
             '{1'b0, 3'h4, `PCC_O_CFG, 32'h0, 32'h0, 2'h2}};
    br = '{32'h190, 32'h12C, 32'hC8};
    bx = '{8'h00, 8'h00, 8'hFF};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        axw(adr(rows[i].ch, rows[i].off), rows[i].wd);
        chk(32'(r), 32'(rows[i].rs));
      end
      axr(adr(rows[i].ch, rows[i].off));
      chk(d, rows[i].ex);
      chk(32'(r), 32'(rows[i].rs));
    end
    // One-bit form on channel 1, two-bit form on channel 3
    for (k = 0; k < 2; k++) begin
      c = k ? 3 : 1;
      axw(adr(c, k ? `PCC_O_CFG : `PCC_O_FVAL), k ? 32'h4C : 32'h33);
      n = rx_cnt[c*8+:8];
      s = st_cnt[c*8+:8];
      axw(adr(c, `PCC_O_FORCE), k ? 32'h3 : 32'h1);
      wt(c, 8'(n + 1));
      chk(rx_val[c*8+:8], k ? 32'h80 : 32'h33);
      axw(adr(c, `PCC_O_MANUAL), 32'h1);
      repeat (4) @(posedge aclk);
      chk(st_cnt[c*8+:8], 32'(s[7:0]));
      axw(adr(c, `PCC_O_FORCE), 32'h0);
      wt(c, 8'(n + 2));
      chk(rx_val[c*8+:8], 32'h0);
    end
    axw(adr(0, `PCC_O_TIMES), 32'h2);
    s = st_cnt[7:0];
    axw(adr(0, `PCC_O_ABSDIM), 32'h80);
    while (st_cnt[7:0] !== 8'(s + 1)) @(posedge aclk);
    chk(rx_auto[0], 32'h0);
    repeat (4) @(posedge aclk);
    axr(adr(0, `PCC_O_STATUS));
    chk(d[15:8], 32'h80);
    chk(d[1], 32'h1);
    axw(adr(0, `PCC_O_RELDIM), 32'h9);
    repeat (4) @(posedge aclk);
    axr(adr(0, `PCC_O_STATUS));
    chk(d[15:8], 32'hFF);
    while (st_cnt[7:0] !== 8'(s + 2)) @(posedge aclk);
    chk(rx_auto[0], 32'h1);
    repeat (4) @(posedge aclk);
    chk(rx_val[7:0], 32'h0);
    n = rx_cnt[23:16];
    motion_in[2] <= 1'b1;
    wt(2, 8'(n + 1));
    chk(rx_val[23:16], 32'hFF);
    motion_in[2] <= 1'b0;
    repeat (5 * SEC) @(posedge aclk);
    motion_in[2] <= 1'b1;
    repeat (8) @(posedge aclk);
    motion_in[2] <= 1'b0;
    c = 0;
    while (rx_val[23:16] !== 8'h00) begin
      @(posedge aclk);
      c++;
    end
    chk(32'(c >= 9 * SEC && c <= 11 * SEC), 32'h1);
    n = rx_cnt[31:24];
    axw(adr(3, `PCC_O_EXTMV), 32'h1);
    wt(3, 8'(n + 1));
    chk(rx_val[31:24], 32'hFF);
    // Middle value sits inside the band and must leave the output alone
    for (k = 0; k < 3; k++) begin
      axw(adr(3, `PCC_O_BRIGHT), br[k]);
      repeat (6) @(posedge aclk);
      chk(rx_val[31:24], 32'(bx[k]));
    end
    // Bright room: only the brightness-independent option lets motion switch on
    axw(adr(0, `PCC_O_BRIGHT), 32'h190);
    axw(adr(0, `PCC_O_CFG), 32'h0E);
    axw(adr(0, `PCC_O_EXTMV), 32'h1);
    repeat (4) @(posedge aclk);
    chk(rx_val[7:0], 32'hFF);
    // Regulating without presence dependence follows darkness with no motion
    axw(adr(1, `PCC_O_CFG), 32'h01);
    repeat (4) @(posedge aclk);
    chk(rx_val[15:8], 32'hFF);
    axw(adr(3, `PCC_O_CFG), 32'h7C);
    axw(adr(3, `PCC_O_LOCK), 32'h1);
    repeat (4) @(posedge aclk);
    axr(adr(3, `PCC_O_STATUS));
    chk(d[0], 32'h1);
    chk(rx_val[31:24], 32'h0);
    axw(adr(3, `PCC_O_LOCK), 32'h0);
    axr(adr(3, `PCC_O_STATUS));
    chk(d[0], 32'h0);
    // Mid-run reset must restore configuration and clear the timers
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'(stat_auto), 32'hF);
    axr(adr(1, `PCC_O_THR));
    chk(d, 32'h12C);
    axr(adr(3, `PCC_O_STATUS));
    chk(d[31:16], 32'h0);
    chk(d[0], 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
